// ### rtl/regulator_ctl.sv
`timescale 1ns/1ps
`default_nettype none
`include "regulator_ctl_params.svh"

module regulator_ctl (
	// Clock and asynchronous reset.
	input  wire logic                            clock_i,
	input  wire logic                            reset_n_i,
	// Analog flags and sync pin, asynchronous.
	input  wire regulator_ctl_pkg::analog_sense_t sense_i,
	input  wire logic                            sync_i,
	// Gate drive requests.
	output regulator_ctl_pkg::gate_drive_t       gate_o,
	// Status.
	output logic                                 input_undervoltage_lockout_o,
	output logic                                 hiccup_active_o,
	output logic                                 pwm_enable_o,
	output logic                                 soft_start_restart_o,
	output logic                                 cycle_start_o,
	output logic                                 sync_locked_o,
	output logic [`COUNT_W-1:0]                  fault_count_o
);

	logic                             reset_meta;
	logic                             reset_n;
	regulator_ctl_pkg::analog_sense_t sense_meta;
	regulator_ctl_pkg::analog_sense_t sense_sync;
	regulator_ctl_pkg::analog_sense_t sense_last;
	logic                             sync_meta;
	logic                             sync_sync;
	logic                             sync_last;
	logic [`TIMER_W-1:0]              osc_count;
	logic [`TIMER_W-1:0]              sync_idle;
	logic                             sync_active;
	logic                             oc_seen;
	logic                             ramp_done;
	regulator_ctl_pkg::ctl_state_t    state;
	regulator_ctl_pkg::ctl_state_t    next_state;
	logic                             next_hs;
	logic                             next_ls;
	logic [`COUNT_W-1:0]              fault_count;
	logic [`COUNT_W-1:0]              good_count;
	logic [`COUNT_W-1:0]              short_count;
	logic                             oc_now;
	logic                             duty_end;
	logic                             ramp_now;
	logic                             ss_done;
	logic                             sync_fall;
	logic                             osc_tick;
	logic                             cycle_start;
	logic                             oc_in_cycle;
	logic                             ramp_short;
	logic                             input_undervoltage_lockout_hit;
	logic                             in_run;
	logic                             in_hiccup;
	logic                             in_lockout;

	// Reset is released through two flops so every flop leaves reset on the same edge.
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reset_meta <= 1'h0;
			reset_n    <= 1'h0;
		end else begin
			reset_meta <= 1'h1;
			reset_n    <= reset_meta;
		end
	end

	// Two-flop synchronisers; a third stage feeds the edge detectors only.
	always_ff @(posedge clock_i or negedge reset_n) begin
		if (!reset_n) begin
			sense_meta <= 4'h0;
			sense_sync <= 4'h0;
			sense_last <= 4'h0;
			sync_meta  <= 1'h0;
			sync_sync  <= 1'h0;
			sync_last  <= 1'h0;
		end else begin
			sense_meta <= sense_i;
			sense_sync <= sense_meta;
			sense_last <= sense_sync;
			sync_meta  <= sync_i;
			sync_sync  <= sync_meta;
			sync_last  <= sync_sync;
		end
	end

	// Decoded events of the current clock cycle.
	assign in_run      = (state == regulator_ctl_pkg::ST_RUN);
	assign in_hiccup   = (state == regulator_ctl_pkg::ST_HICCUP);
	assign in_lockout  = (state == regulator_ctl_pkg::ST_LOCKOUT);
	assign oc_now      = sense_sync.overcurrent_threshold_sense;
	assign duty_end    = sense_sync.duty_end;
	assign ramp_now    = sense_sync.ramp_at_90;
	assign ss_done     = sense_sync.soft_start_done && !sense_last.soft_start_done;
	assign sync_fall   = sync_last && !sync_sync;
	assign osc_tick    = (osc_count == `TIMER_W'(`FREE_RUN_CYCLES - 1));
	assign cycle_start = sync_active ? sync_fall : osc_tick;
	assign oc_in_cycle = oc_seen || (oc_now && gate_o.high_side_gate_drive);
	assign ramp_short  = !ramp_done && !ramp_now;
	assign input_undervoltage_lockout_hit    = (short_count == `FILTER_LIMIT)
		|| (cycle_start && sync_active && ramp_short);

	// Internal oscillator runs free so it is ready the moment sync goes away.
	always_ff @(posedge clock_i or negedge reset_n) begin
		if (!reset_n) begin
			osc_count <= `TIMER_W'(0);
		end else if (osc_tick) begin
			osc_count <= `TIMER_W'(0);
		end else begin
			osc_count <= osc_count + `TIMER_W'(1);
		end
	end

	// Sync counts as active until two free-run periods pass with no falling edge.
	// A source run 20% to 30% faster than free-run always lands well inside that window.
	always_ff @(posedge clock_i or negedge reset_n) begin
		if (!reset_n) begin
			sync_idle   <= `TIMER_W'(0);
			sync_active <= 1'h0;
		end else if (sync_fall) begin
			sync_idle   <= `TIMER_W'(0);
			sync_active <= 1'h1;
		end else if (sync_idle == `TIMER_W'(`SYNC_LOSS_CYCLES - 1)) begin
			sync_active <= 1'h0;
		end else begin
			sync_idle   <= sync_idle + `TIMER_W'(1);
		end
	end

	// Per-cycle flags; the event seen at cycle start is used through the decoded terms.
	always_ff @(posedge clock_i or negedge reset_n) begin
		if (!reset_n) begin
			oc_seen   <= 1'h0;
			ramp_done <= 1'h0;
		end else if (cycle_start) begin
			oc_seen   <= 1'h0;
			ramp_done <= 1'h0;
		end else begin
			if (oc_now && gate_o.high_side_gate_drive) begin
				oc_seen <= 1'h1;
			end
			if (ramp_now) begin
				ramp_done <= 1'h1;
			end
		end
	end

	// Fault counter: trips and clean cycles in run, soft-start completions in hiccup.
	sat_count3 fault_counter (
		.clock_i   (clock_i),
		.reset_n_i (reset_n),
		.clear_i   (in_lockout),
		.up_i      (in_run && cycle_start && oc_in_cycle),
		.down_i    ((in_run && cycle_start && !oc_in_cycle) || (in_hiccup && ss_done)),
		.count_o   (fault_count)
	);

	// Good-ramp filter counts only while locked out.
	sat_count3 good_filter (
		.clock_i   (clock_i),
		.reset_n_i (reset_n),
		.clear_i   (!in_lockout),
		.up_i      (in_lockout && cycle_start && !ramp_short),
		.down_i    (1'h0),
		.count_o   (good_count)
	);

	// Short-ramp filter counts only while released.
	sat_count3 short_filter (
		.clock_i   (clock_i),
		.reset_n_i (reset_n),
		.clear_i   (in_lockout),
		.up_i      (!in_lockout && cycle_start && ramp_short),
		.down_i    (1'h0),
		.count_o   (short_count)
	);

	assign fault_count_o = fault_count;

	// Next control state; lockout takes priority over the fault path.
	always_comb begin
		next_state = state;
		case (state)
			regulator_ctl_pkg::ST_LOCKOUT: begin
				if (good_count == `FILTER_LIMIT) begin
					next_state = regulator_ctl_pkg::ST_RUN;
				end
			end
			regulator_ctl_pkg::ST_RUN: begin
				if (input_undervoltage_lockout_hit) begin
					next_state = regulator_ctl_pkg::ST_LOCKOUT;
				end else if (fault_count == `FAULT_LIMIT) begin
					next_state = regulator_ctl_pkg::ST_HICCUP;
				end
			end
			regulator_ctl_pkg::ST_HICCUP: begin
				if (input_undervoltage_lockout_hit) begin
					next_state = regulator_ctl_pkg::ST_LOCKOUT;
				end else if (fault_count == `COUNT_ZERO) begin
					next_state = regulator_ctl_pkg::ST_RUN;
				end
			end
			default: begin
				next_state = regulator_ctl_pkg::ST_LOCKOUT;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge reset_n) begin
		if (!reset_n) begin
			state <= regulator_ctl_pkg::ST_LOCKOUT;
		end else begin
			state <= next_state;
		end
	end

	// Drive requests; the cut acts on the synchronised trip, two clocks after the pin.
	always_comb begin
		next_hs = gate_o.high_side_gate_drive;
		if (!in_run || next_state != regulator_ctl_pkg::ST_RUN) begin
			next_hs = 1'h0;
		end else if (cycle_start) begin
			next_hs = 1'h1;
		end else if (oc_now || duty_end) begin
			next_hs = 1'h0;
		end
		// One idle clock after the high side ends before the low side drives; the low side drops on the same edge the high side rises.
		next_ls = in_run && next_state == regulator_ctl_pkg::ST_RUN
			&& !gate_o.high_side_gate_drive && !next_hs;
	end

	always_ff @(posedge clock_i or negedge reset_n) begin
		if (!reset_n) begin
			gate_o <= 2'h0;
		end else begin
			gate_o.high_side_gate_drive <= next_hs;
			gate_o.low_side_gate_drive  <= next_ls;
		end
	end

	// Registered status; soft-start restarts on each start and each hiccup cycle.
	always_ff @(posedge clock_i or negedge reset_n) begin
		if (!reset_n) begin
			input_undervoltage_lockout_o <= 1'h1;
			hiccup_active_o              <= 1'h0;
			pwm_enable_o                 <= 1'h0;
			soft_start_restart_o         <= 1'h0;
			cycle_start_o                <= 1'h0;
			sync_locked_o                <= 1'h0;
		end else begin
			input_undervoltage_lockout_o <= (next_state == regulator_ctl_pkg::ST_LOCKOUT);
			hiccup_active_o              <= (next_state == regulator_ctl_pkg::ST_HICCUP);
			pwm_enable_o                 <= (next_state == regulator_ctl_pkg::ST_RUN);
			soft_start_restart_o         <= (!in_run && next_state == regulator_ctl_pkg::ST_RUN)
				|| (in_run && next_state == regulator_ctl_pkg::ST_HICCUP)
				|| (in_hiccup && next_state == regulator_ctl_pkg::ST_HICCUP
				&& ss_done && fault_count > `COUNT_ONE);
			cycle_start_o                <= cycle_start;
			sync_locked_o                <= sync_active;
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n);

	a_oc_ends_pulse: assert property (
		(oc_now && gate_o.high_side_gate_drive && !cycle_start) |=> !gate_o.high_side_gate_drive)
		else $error("high-side pulse survived an overcurrent trip");

	a_oc_needs_drive: assert property (
		$rose(oc_seen) |-> $past(gate_o.high_side_gate_drive))
		else $error("trip recorded while the high side was off");

	a_off_until_cycle: assert property (
		(!gate_o.high_side_gate_drive && !cycle_start) |=> !gate_o.high_side_gate_drive)
		else $error("high side turned on outside a cycle start");

	a_trip_counts_up: assert property (
		(in_run && cycle_start && oc_in_cycle && fault_count != `FAULT_LIMIT)
		|=> fault_count == $past(fault_count) + `COUNT_ONE)
		else $error("fault counter missed an overcurrent cycle");

	a_hiccup_entry: assert property (
		(in_run && !input_undervoltage_lockout_hit && fault_count == `FAULT_LIMIT)
		|=> (in_hiccup && soft_start_restart_o))
		else $error("hiccup not entered at fault count seven");

	a_hiccup_drives_off: assert property (
		in_hiccup |-> (gate_o == 2'h0))
		else $error("gate drive active during hiccup");

	a_hiccup_decrement: assert property (
		(in_hiccup && ss_done && fault_count != `COUNT_ZERO)
		|=> fault_count == $past(fault_count) - `COUNT_ONE)
		else $error("soft-start completion not counted in hiccup");

	a_hiccup_exit: assert property (
		(in_hiccup && !input_undervoltage_lockout_hit && fault_count == `COUNT_ZERO)
		|=> (in_run && pwm_enable_o && soft_start_restart_o))
		else $error("modulation not re-enabled after hiccup");

	a_sync_starts_cycle: assert property (
		(sync_active && sync_fall) |-> cycle_start ##1 cycle_start_o)
		else $error("sync falling edge did not start a cycle");

	a_free_run_source: assert property (
		!sync_active |-> (cycle_start == osc_tick))
		else $error("free-running cycle not from the oscillator");

	a_sync_cut_ramp: assert property (
		(!in_lockout && sync_active && cycle_start && ramp_short)
		|=> (in_lockout && input_undervoltage_lockout_o && !pwm_enable_o))
		else $error("short ramp under sync did not lock out");

	c_hiccup_entered: cover property (in_run ##1 in_hiccup);
	c_sync_lockout: cover property (sync_active && cycle_start && ramp_short && in_run);
	c_oc_cut: cover property (gate_o.high_side_gate_drive && oc_now && !cycle_start);
	c_hiccup_recovery: cover property (in_hiccup ##1 in_run);

endmodule : regulator_ctl
`default_nettype wire

// ### pkg/regulator_ctl_params.svh
// What this block does
// - Overcurrent is only looked at while the high-side drive is on.
// - An overcurrent trip ends the high-side pulse at once, before the duty end.
// - After a trip the high-side drive stays off until the next switching cycle starts.
// - The fault counter goes up per cycle with a trip and down per cycle without one.
// - At a fault count of 7 the block enters hiccup and restarts seven soft-start cycles.
// - In hiccup both gate drives are held off.
// - In hiccup the fault counter goes down once per finished soft-start cycle.
// - When hiccup brings the counter to zero, modulation is enabled and a normal start follows.
// - A toggling sync input starts each switching cycle on its falling edge.
// - While sync is active its clock replaces the internal oscillator as master clock.
// - With sync held low the block free-runs from the internal oscillator.
// - A sync edge that cuts the ramp short declares lockout and disables modulation.
// - A cycle is short when its edge comes before the ramp reaches 90% of full swing.
// - Seven good ramps start soft-start and seven short ramps declare lockout (3-bit filter).
`ifndef REGULATOR_CTL_PARAMS_SVH
`define REGULATOR_CTL_PARAMS_SVH

`define CLK_PERIOD_NS      8
`define FREE_RUN_PERIOD_NS 1000
`define FREE_RUN_CYCLES    (`FREE_RUN_PERIOD_NS / `CLK_PERIOD_NS)
`define SYNC_LOSS_PERIODS  2
`define SYNC_LOSS_CYCLES   (`SYNC_LOSS_PERIODS * `FREE_RUN_CYCLES)
`define TIMER_W            9
`define COUNT_W            3
`define FAULT_LIMIT        3'h7
`define FILTER_LIMIT       3'h7
`define COUNT_ZERO         3'h0
`define COUNT_ONE          3'h1

`endif

// ### pkg/regulator_ctl_pkg.sv
`default_nettype none
package regulator_ctl_pkg;

	// Control states of the switching controller.
	typedef enum logic [1:0] {
		ST_LOCKOUT,
		ST_RUN,
		ST_HICCUP
	} ctl_state_t;

	// Analog comparator and soft-start flags, all asynchronous to clock_i.
	typedef struct packed {
		logic overcurrent_threshold_sense;
		logic duty_end;
		logic ramp_at_90;
		logic soft_start_done;
	} analog_sense_t;

	// The two gate drive requests.
	typedef struct packed {
		logic high_side_gate_drive;
		logic low_side_gate_drive;
	} gate_drive_t;

endpackage : regulator_ctl_pkg
`default_nettype wire

// ### rtl/sat_count3.sv
`timescale 1ns/1ps
`default_nettype none
`include "regulator_ctl_params.svh"

module sat_count3 (
	// Clock and synchronised reset.
	input  wire logic                  clock_i,
	input  wire logic                  reset_n_i,
	// Count controls.
	input  wire logic                  clear_i,
	input  wire logic                  up_i,
	input  wire logic                  down_i,
	// Current count.
	output logic [`COUNT_W-1:0]        count_o
);

	// Saturating count; clear has priority, opposing requests cancel.
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_o <= `COUNT_ZERO;
		end else if (clear_i) begin
			count_o <= `COUNT_ZERO;
		end else if (up_i && !down_i && count_o != `FAULT_LIMIT) begin
			count_o <= count_o + `COUNT_ONE;
		end else if (down_i && !up_i && count_o != `COUNT_ZERO) begin
			count_o <= count_o - `COUNT_ONE;
		end
	end

	a_count_ceiling: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(count_o == `FAULT_LIMIT && up_i && !down_i && !clear_i) |=> count_o == `FAULT_LIMIT)
		else $error("count wrapped past its ceiling");

	a_count_floor: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(count_o == `COUNT_ZERO && down_i && !up_i && !clear_i) |=> count_o == `COUNT_ZERO)
		else $error("count wrapped below zero");

endmodule : sat_count3
`default_nettype wire

// ### sim/regulator_ctl_partner.sv
`timescale 1ns/1ps
`default_nettype none

// Far side of the controller: current comparator, duty compare, ramp, soft-start and sync source.
module regulator_ctl_partner #(
	parameter int SS_CLOCKS   = 60,
	parameter int DUTY_CLOCKS = 40
) (
	// Clock.
	input  wire logic                           clock_i,
	// Commands from the bench.
	input  wire logic                           trip_en_i,
	input  wire logic [2:0]                     trip_delay_i,
	input  wire logic                           ramp_good_i,
	input  wire logic                           sync_en_i,
	input  wire logic [7:0]                     sync_period_i,
	// Design side.
	input  wire regulator_ctl_pkg::gate_drive_t gate_i,
	input  wire logic                           restart_i,
	output regulator_ctl_pkg::analog_sense_t    sense_o,
	output logic                                sync_o
);
	int on_count   = 0;
	int ss_count   = 0;
	int sync_count = 0;

	initial begin
		sense_o = '0;
		sync_o  = 1'b0;
	end

	// Trip and duty end follow the high-side pulse and drop as soon as it is off.
	always @(posedge clock_i) begin
		on_count <= gate_i.high_side_gate_drive ? on_count + 1 : 0;
		sense_o.overcurrent_threshold_sense <= trip_en_i && gate_i.high_side_gate_drive &&
			(on_count + 1 >= int'(trip_delay_i));
		sense_o.duty_end <= gate_i.high_side_gate_drive && (on_count + 1 >= DUTY_CLOCKS);
		sense_o.ramp_at_90 <= ramp_good_i;
	end

	// Each restart runs a soft-start; its end is a two-clock pulse so the synchroniser sees it.
	always @(posedge clock_i) begin
		if (restart_i) begin
			ss_count <= SS_CLOCKS;
		end else if (ss_count > 0) begin
			ss_count <= ss_count - 1;
		end
		sense_o.soft_start_done <= (ss_count != 0) && (ss_count <= 2);
	end

	// The sync pin is held low when unused, so the block free-runs.
	always @(posedge clock_i) begin
		if (!sync_en_i) begin
			sync_count <= 0;
			sync_o     <= 1'b0;
		end else begin
			sync_count <= (sync_count + 1 >= int'(sync_period_i)) ? 0 : sync_count + 1;
			sync_o     <= sync_count < int'(sync_period_i) / 2;
		end
	end
endmodule : regulator_ctl_partner

`default_nettype wire

// ### sim/regulator_ctl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "regulator_ctl_params.svh"

module regulator_ctl_bench;
	logic                          clock_i     = 1'b0;
	logic                          reset_n_i   = 1'b0;
	logic                          trip_en     = 1'b0;
	logic                          ramp_good   = 1'b0;
	logic                          sync_en     = 1'b0;
	logic [2:0]                    trip_delay  = 3'h1;
	logic [7:0]                    sync_period = 8'h64;
	regulator_ctl_pkg::analog_sense_t sense;
	regulator_ctl_pkg::gate_drive_t   gate;
	logic                          sync, input_undervoltage_lockout, hiccup, pwm, restart, cs, locked, last_hs;
	logic [`COUNT_W-1:0]           count, last_count;
	logic [`COUNT_W-1:0]           expq[$];
	logic [31:0]                   seed        = 32'h00004E8D;
	int                            mismatches  = 0;
	int                            tests_run   = 0;
	int                            restarts    = 0;
	int                            width       = 0;

	// Free-running 125 MHz clock.
	always #4 clock_i = ~clock_i;

	regulator_ctl u_dut (
		.clock_i                      (clock_i),
		.reset_n_i                    (reset_n_i),
		.sense_i                      (sense),
		.sync_i                       (sync),
		.gate_o                       (gate),
		.input_undervoltage_lockout_o (input_undervoltage_lockout),
		.hiccup_active_o              (hiccup),
		.pwm_enable_o                 (pwm),
		.soft_start_restart_o         (restart),
		.cycle_start_o                (cs),
		.sync_locked_o                (locked),
		.fault_count_o                (count)
	);

	regulator_ctl_partner u_partner (
		.clock_i       (clock_i),
		.trip_en_i     (trip_en),
		.trip_delay_i  (trip_delay),
		.ramp_good_i   (ramp_good),
		.sync_en_i     (sync_en),
		.sync_period_i (sync_period),
		.gate_i        (gate),
		.restart_i     (restart),
		.sense_o       (sense),
		.sync_o        (sync)
	);

	// Compares one observed value with its expectation.
	task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
		tests_run++;
		if (seen !== want) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s seen %0h want %0h", $time, what, seen, want);
		end
	endtask : check

	task automatic print_verdict();
		if (mismatches == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict

	function automatic logic [31:0] next_rand(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : next_rand

	function automatic logic pick(input int sel);
		case (sel)
			0: return pwm;
			1: return hiccup;
			2: return locked;
			3: return !locked;
			default: return input_undervoltage_lockout;
		endcase
	endfunction : pick

	// Bounded wait for a status level; running out counts as a mismatch.
	task automatic wait_until(input int sel, input int limit);
		int n;
		n = 0;
		while (pick(sel) !== 1'b1 && n < limit) begin
			@(posedge clock_i);
			n++;
		end
		check(pick(sel), 1'b1, "status wait");
	endtask : wait_until

	// Clocks up to and including the next cycle start pulse.
	task automatic wait_cs(output int n);
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (cs !== 1'b1 && n < 2000);
	endtask : wait_cs

	// Watches the outputs and takes the oldest noted count whenever the count moves.
	always @(posedge clock_i) begin
		last_count <= count;
		last_hs    <= gate.high_side_gate_drive;
		if (reset_n_i && count !== last_count) begin
			if (expq.size() == 0) begin
				check(1'b1, 1'b0, "unexpected count change");
			end else begin
				check(count, expq.pop_front(), "fault count");
			end
		end
		if (gate.high_side_gate_drive === 1'b1) begin
			width <= width + 1;
			if (last_hs !== 1'b1) begin
				check(cs, 1'b1, "pulse outside cycle start");
			end
		end else begin
			width <= 0;
			// The pulse that starts on the edge the count reaches seven is cut by hiccup, not by the trip.
			if (last_hs === 1'b1 && hiccup === 1'b1) begin
				check(width, 1, "pulse cut by hiccup");
			end else if (last_hs === 1'b1 && trip_en) begin
				check(width, int'(trip_delay) + 3, "trip pulse width");
			end
		end
		if (hiccup === 1'b1) begin
			check(gate, 2'h0, "drive in hiccup");
			if (restart === 1'b1) begin
				restarts <= restarts + 1;
			end
		end
	end

	// A hang ends the run through the same verdict.
	initial begin
		repeat (20000) @(posedge clock_i);
		mismatches++;
		print_verdict();
	end

	initial begin
		int n;
		int i;
		last_count = '0;
		last_hs    = 1'b0;
		repeat (20) @(posedge clock_i);
		check(input_undervoltage_lockout, 1'b1, "reset lockout");
		check(gate, 2'h0, "reset drive");
		check(count, 3'h0, "reset count");
		reset_n_i <= 1'b1;
		ramp_good <= 1'b1;
		// Seven good ramps leave lockout, then the oscillator spacing is measured.
		wait_until(0, 1200);
		check(input_undervoltage_lockout, 1'b0, "lockout released");
		wait_cs(n);
		wait_cs(n);
		check(n, `FREE_RUN_CYCLES, "free-run period");
		// Repeated trips fill the counter, hiccup runs its restarts and empties it.
		seed = next_rand(seed);
		trip_delay <= 3'h1 + 3'(seed[1:0]);
		repeat (60) @(posedge clock_i);
		for (i = 1; i <= 7; i++) expq.push_back(3'(i));
		for (i = 6; i >= 0; i--) expq.push_back(3'(i));
		trip_en <= 1'b1;
		wait_until(1, 1100);
		trip_en <= 1'b0;
		wait_until(0, 800);
		check(restarts, 7, "hiccup restarts");
		check(count, 3'h0, "count after hiccup");
		check(expq.size(), 0, "count steps left");
		// External sync 22 to 28 percent faster than free-run takes over the cycle.
		seed = next_rand(seed);
		sync_period <= 8'h62 + 8'(seed[7:0] % 5);
		sync_en <= 1'b1;
		wait_until(2, 300);
		wait_cs(n);
		wait_cs(n);
		wait_cs(n);
		check(n, int'(sync_period), "sync period");
		// Sync held low again: lock is lost and the oscillator resumes.
		sync_en <= 1'b0;
		wait_until(3, 400);
		wait_cs(n);
		wait_cs(n);
		wait_cs(n);
		check(n, `FREE_RUN_CYCLES, "period after sync loss");
		// A sync edge that cuts a short ramp forces lockout at once.
		sync_en <= 1'b1;
		wait_until(2, 300);
		wait_cs(n);
		ramp_good <= 1'b0;
		wait_until(4, 260);
		@(posedge clock_i);
		check(pwm, 1'b0, "pwm off in lockout");
		check(gate, 2'h0, "drive off in lockout");
		check(count, 3'h0, "count cleared");
		// Free-running short ramps must pass the seven-count filter before lockout.
		sync_en   <= 1'b0;
		ramp_good <= 1'b1;
		wait_until(0, 1400);
		ramp_good <= 1'b0;
		repeat (6 * `FREE_RUN_CYCLES) @(posedge clock_i);
		check(input_undervoltage_lockout, 1'b0, "lockout before seven short ramps");
		wait_until(4, 3 * `FREE_RUN_CYCLES);
		check(pwm, 1'b0, "pwm off after short ramps");
		check(gate, 2'h0, "drive off after short ramps");
		print_verdict();
	end
endmodule : regulator_ctl_bench

`default_nettype wire
